/* File: clp_pkg.sv */
// shared constants, types and helpers for the cascade led packet loader
package clp_pkg;

    // clock and bit-period timing
    localparam int CLK_PERIOD_NS     = 40;
    localparam int BIT_PERIOD_MIN_NS = 1660;
    localparam int BIT_PERIOD_MAX_NS = 50000;
    localparam int BIT_MIN_CYC       = (BIT_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_MAX_CYC       = BIT_PERIOD_MAX_NS / CLK_PERIOD_NS;
    localparam int PERIOD_W          = 11;

    // gap thresholds as multiples of the measured bit period
    localparam int EOS_MULT          = 4;
    localparam int LATCH_MULT        = 8;
    localparam int GAP_W             = 14;

    // packet layout
    localparam int PACKET_W          = 32;
    localparam int LEVEL_W           = 24;
    localparam int CHAN_W            = 8;
    localparam int CHANNELS          = 3;
    localparam int CMD_LSB           = 24;
    localparam int CH2_LSB           = 0;
    localparam int CH1_LSB           = 8;
    localparam int CH0_LSB           = 16;
    localparam logic [7:0]  WRITE_COMMAND = 8'h3a;
    localparam logic [31:0] SHIFT_RESET   = 32'h0000_0000;
    localparam logic [23:0] LEVEL_RESET   = 24'h00_0000;

    // host waveform shape within one bit period
    localparam int HOST_HIGH_DIV     = 8;
    localparam int HOST_ONE_DIV      = 4;
    localparam int HOST_BIT_CYC      = 250;

    typedef enum {
        CLP_WAIT_FIRST,
        CLP_WAIT_SECOND,
        CLP_RECEIVE,
        CLP_FORWARD
    } clp_dev_state_t;

    typedef enum {
        CLP_IDLE,
        CLP_BITS,
        CLP_GAP
    } clp_host_state_t;

    function automatic logic [GAP_W-1:0] clp_gap_limit(input logic [PERIOD_W-1:0] period,
                                                       input int unsigned         mult);
        return GAP_W'(period * mult);
    endfunction

endpackage

/* File: clp_link_if.sv */
// single-wire serial link between a host end and a device end
`timescale 1ns/1ps
interface clp_link_if;
    logic serial_data;

    modport host_end   (output serial_data);
    modport device_end (input  serial_data);
endinterface

/* File: clp_pwm_channel.sv */
// one pwm sink channel, restartable counter
`timescale 1ns/1ps
module clp_pwm_channel #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic             restart,
    input  wire logic [WIDTH-1:0] level,
    output logic                  sink_on
);
    logic [WIDTH-1:0] pwm_count;

    // zero level never switches on; duty is level out of 2**WIDTH
    wire next_on = (level != '0) && (pwm_count < level);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_count <= '0;
            sink_on   <= 1'b0;
        end else if (ce) begin
            if (restart) begin
                pwm_count <= '0;
                sink_on   <= 1'b0;
            end else begin
                pwm_count <= pwm_count + 1'b1;
                sink_on   <= next_on;
            end
        end
    end
endmodule // clp_pwm_channel

/* File: clp_device.sv */
// device end: edge-timed packet receiver, gray level latch and pwm outputs
`timescale 1ns/1ps

// What this block does
// - sinks stay off until levels are written
// - host sends 32 bits, msb first
// - first eight bits are the command
// - host sends command 3Ah
// - host gaps after each device packet
// - host keeps one bit period throughout
// - host repeats packet per chained device
// - latch gap copies low 24 bits
// - pwm restarts with new levels at latch
// - 32-bit shift register, separate 24-bit latch
// - wrong command leaves the latch unchanged
// - bits 0-7 ch2, 8-15 ch1, 16-23 ch0
// - command sits in bits 24 upward
// - first two edges measure the bit period
// - edge before half period means one
// - end gap locks register, forwards input
// - long low gap triggers latch copy
module clp_device #(
    parameter int PERIOD_W = clp_pkg::PERIOD_W,
    parameter int GAP_W    = clp_pkg::GAP_W
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    ce,
    clp_link_if.device_end               link,
    output logic                         serial_out,
    output logic [clp_pkg::CHAN_W-1:0]   level_ch0,
    output logic [clp_pkg::CHAN_W-1:0]   level_ch1,
    output logic [clp_pkg::CHAN_W-1:0]   level_ch2,
    output logic [clp_pkg::CHANNELS-1:0] sink_output,
    output logic                         packet_locked
);
    clp_pkg::clp_dev_state_t state;

    logic [clp_pkg::PACKET_W-1:0] packet_shift_register;
    logic [clp_pkg::LEVEL_W-1:0]  gray_level;
    logic [PERIOD_W-1:0]          bit_period;
    logic [PERIOD_W-1:0]          bit_count;
    logic [GAP_W-1:0]             low_count;
    logic                         prev_in;
    logic                         bit_pending;
    logic                         one_seen;
    logic                         restart_pwm;

    // input is taken as synchronous, so no synchroniser stage
    wire serial_in = link.serial_data;
    wire rise      = serial_in && !prev_in;

    // elapsed cycles since the last bit boundary, counting this one
    wire [PERIOD_W-1:0] elapsed   = bit_count + 1'b1;
    wire [PERIOD_W-1:0] half      = {1'b0, bit_period[PERIOD_W-1:1]};
    wire                early     = elapsed < half;
    wire                one_edge  = rise && early && bit_pending;
    wire                boundary  = rise && !one_edge;

    wire [GAP_W-1:0] eos_limit   = clp_pkg::clp_gap_limit(bit_period, clp_pkg::EOS_MULT);
    wire [GAP_W-1:0] latch_limit = clp_pkg::clp_gap_limit(bit_period, clp_pkg::LATCH_MULT);
    wire             counting    = (state == clp_pkg::CLP_RECEIVE)
                                || (state == clp_pkg::CLP_FORWARD);
    wire             eos_hit     = (state == clp_pkg::CLP_RECEIVE) && !serial_in
                                && (low_count == eos_limit);
    wire             latch_hit   = counting && !serial_in
                                && (low_count == latch_limit);

    wire [7:0] command_field = packet_shift_register[clp_pkg::CMD_LSB +: 8];
    wire       command_ok    = command_field == clp_pkg::WRITE_COMMAND;

    // msb arrives first, so each new bit enters at bit 0
    wire [clp_pkg::PACKET_W-1:0] shifted_in =
        {packet_shift_register[clp_pkg::PACKET_W-2:0], one_seen};

    wire [PERIOD_W-1:0] period_max = PERIOD_W'(clp_pkg::BIT_MAX_CYC);
    wire [PERIOD_W-1:0] period_min = PERIOD_W'(clp_pkg::BIT_MIN_CYC);
    wire [PERIOD_W-1:0] next_period = (elapsed < period_min) ? period_min : elapsed;

    // edge history and low-time counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_in   <= 1'b0;
            low_count <= '0;
        end else if (ce) begin
            prev_in <= serial_in;
            if (rise) begin
                low_count <= '0;
            end else if (!serial_in && (low_count != '1)) begin
                low_count <= low_count + 1'b1;
            end
        end
    end

    // cycles since the last bit boundary, saturating at the slowest period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_count <= '0;
        end else if (ce) begin
            if (boundary) begin
                bit_count <= '0;
            end else if (bit_count != period_max) begin
                bit_count <= elapsed;
            end
        end
    end

    // receive state machine
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state                 <= clp_pkg::CLP_WAIT_FIRST;
            packet_shift_register <= clp_pkg::SHIFT_RESET;
            bit_period            <= PERIOD_W'(clp_pkg::BIT_MAX_CYC);
            bit_pending           <= 1'b0;
            one_seen              <= 1'b0;
        end else if (ce) begin
            case (state)
                clp_pkg::CLP_WAIT_FIRST: begin
                    if (rise) begin
                        state <= clp_pkg::CLP_WAIT_SECOND;
                    end
                end
                clp_pkg::CLP_WAIT_SECOND: begin
                    if (rise) begin
                        bit_period            <= next_period;
                        // the two measuring edges count as two zero bits
                        packet_shift_register <= {packet_shift_register[clp_pkg::PACKET_W-3:0],
                                                  2'b00};
                        bit_pending           <= 1'b0;
                        one_seen              <= 1'b0;
                        state                 <= clp_pkg::CLP_RECEIVE;
                    end
                end
                clp_pkg::CLP_RECEIVE: begin
                    if (latch_hit) begin
                        state <= clp_pkg::CLP_WAIT_FIRST;
                    end else if (eos_hit) begin
                        // last bit has no closing edge, the gap ends it
                        if (bit_pending) begin
                            packet_shift_register <= shifted_in;
                        end
                        bit_pending <= 1'b0;
                        one_seen    <= 1'b0;
                        state       <= clp_pkg::CLP_FORWARD;
                    end else if (one_edge) begin
                        one_seen <= 1'b1;
                    end else if (boundary) begin
                        if (bit_pending) begin
                            packet_shift_register <= shifted_in;
                        end
                        bit_pending <= 1'b1;
                        one_seen    <= 1'b0;
                    end
                end
                clp_pkg::CLP_FORWARD: begin
                    // register frozen; downstream traffic is not decoded here
                    if (latch_hit) begin
                        state <= clp_pkg::CLP_WAIT_FIRST;
                    end
                end
                default: begin
                    state <= clp_pkg::CLP_WAIT_FIRST;
                end
            endcase
        end
    end

    // gray level latch, loaded only on the latch gap with a good command
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gray_level  <= clp_pkg::LEVEL_RESET;
            restart_pwm <= 1'b0;
        end else if (ce) begin
            restart_pwm <= latch_hit;
            if (latch_hit && command_ok) begin
                gray_level <= packet_shift_register[clp_pkg::LEVEL_W-1:0];
            end
        end
    end

    // buffered pass-through once locked
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_out    <= 1'b0;
            packet_locked <= 1'b0;
        end else if (ce) begin
            serial_out    <= (state == clp_pkg::CLP_FORWARD) && serial_in;
            packet_locked <= (state == clp_pkg::CLP_FORWARD) && !latch_hit;
        end
    end

    assign level_ch0 = gray_level[clp_pkg::CH0_LSB +: clp_pkg::CHAN_W];
    assign level_ch1 = gray_level[clp_pkg::CH1_LSB +: clp_pkg::CHAN_W];
    assign level_ch2 = gray_level[clp_pkg::CH2_LSB +: clp_pkg::CHAN_W];

    wire [clp_pkg::CHAN_W-1:0] chan_level [clp_pkg::CHANNELS];
    assign chan_level[0] = level_ch0;
    assign chan_level[1] = level_ch1;
    assign chan_level[2] = level_ch2;

    // new levels land one edge before the counters restart, so the first
    // period after a latch already uses them
    for (genvar c = 0; c < clp_pkg::CHANNELS; c++) begin : g_chan
        clp_pwm_channel #(
            .WIDTH   (clp_pkg::CHAN_W)
        ) u_pwm (
            .clk     (clk),
            .reset_n (reset_n),
            .ce      (ce),
            .restart (restart_pwm),
            .level   (chan_level[c]),
            .sink_on (sink_output[c])
        );
    end
endmodule // clp_device

/* File: clp_host.sv */
// host end: sends one packet per request, then an end gap or a latch gap
`timescale 1ns/1ps
module clp_host #(
    parameter int BIT_CYCLES = clp_pkg::HOST_BIT_CYC,
    parameter int GAP_W      = clp_pkg::GAP_W
) (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       ce,
    input  wire logic                       send_valid,
    input  wire logic [clp_pkg::LEVEL_W-1:0] send_levels,
    input  wire logic                       send_last,
    output logic                            send_ready,
    clp_link_if.host_end                    link
);
    localparam logic [GAP_W-1:0] BIT_END   = GAP_W'(BIT_CYCLES - 1);
    localparam logic [GAP_W-1:0] HIGH_LEN  = GAP_W'(BIT_CYCLES / clp_pkg::HOST_HIGH_DIV);
    localparam logic [GAP_W-1:0] ONE_START = GAP_W'(BIT_CYCLES / clp_pkg::HOST_ONE_DIV);
    localparam logic [GAP_W-1:0] EOS_END   = GAP_W'((clp_pkg::EOS_MULT + 1) * BIT_CYCLES - 1);
    localparam logic [GAP_W-1:0] LATCH_END = GAP_W'((clp_pkg::LATCH_MULT + 1) * BIT_CYCLES - 1);

    clp_pkg::clp_host_state_t state;

    logic [clp_pkg::PACKET_W-1:0] packet;
    logic [4:0]                   bit_idx;
    logic [GAP_W-1:0]             phase;
    logic                         is_last;

    wire cur_bit   = packet[clp_pkg::PACKET_W-1];
    wire in_high   = phase < HIGH_LEN;
    wire in_one    = cur_bit && (phase >= ONE_START) && (phase < ONE_START + HIGH_LEN);
    wire next_line = (state == clp_pkg::CLP_BITS) && (in_high || in_one);
    wire gap_end   = phase == (is_last ? LATCH_END : EOS_END);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state            <= clp_pkg::CLP_IDLE;
            packet           <= clp_pkg::SHIFT_RESET;
            bit_idx          <= '0;
            phase            <= '0;
            is_last          <= 1'b0;
            send_ready       <= 1'b1;
            link.serial_data <= 1'b0;
        end else if (ce) begin
            link.serial_data <= next_line;
            case (state)
                clp_pkg::CLP_IDLE: begin
                    if (send_valid) begin
                        // two leading zeros of the command double as the measuring edges
                        packet     <= {clp_pkg::WRITE_COMMAND, send_levels};
                        is_last    <= send_last;
                        bit_idx    <= '0;
                        phase      <= '0;
                        send_ready <= 1'b0;
                        state      <= clp_pkg::CLP_BITS;
                    end
                end
                clp_pkg::CLP_BITS: begin
                    if (phase == BIT_END) begin
                        // fixed period for every packet, so downstream devices agree
                        phase  <= '0;
                        packet <= {packet[clp_pkg::PACKET_W-2:0], 1'b0};
                        if (bit_idx == 5'(clp_pkg::PACKET_W - 1)) begin
                            state <= clp_pkg::CLP_GAP;
                        end
                        bit_idx <= bit_idx + 1'b1;
                    end else begin
                        phase <= phase + 1'b1;
                    end
                end
                clp_pkg::CLP_GAP: begin
                    if (gap_end) begin
                        send_ready <= 1'b1;
                        state      <= clp_pkg::CLP_IDLE;
                    end else begin
                        phase <= phase + 1'b1;
                    end
                end
                default: begin
                    state <= clp_pkg::CLP_IDLE;
                end
            endcase
        end
    end
endmodule // clp_host

/* File: clp_link_properties.sv */
// link and first-device checks for the cascade led packet loader
`timescale 1ns/1ps
module clp_link_properties #(
    parameter int BIT_CYCLES = clp_pkg::HOST_BIT_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire logic                         serial_data,
    input  wire logic                         send_valid,
    input  wire logic                         send_ready,
    input  wire logic                         serial_out,
    input  wire logic                         packet_locked,
    input  wire logic [clp_pkg::CHAN_W-1:0]   level_ch0,
    input  wire logic [clp_pkg::CHANNELS-1:0] sink_output
);
    // windows leave a few cycles of pipeline slack either side
    localparam logic [15:0] LOCK_LO  = 16'(4 * BIT_CYCLES - 2);
    localparam logic [15:0] LOCK_HI  = 16'(4 * BIT_CYCLES + 3);
    localparam logic [15:0] LATCH_LO = 16'(8 * BIT_CYCLES - 2);
    localparam logic [15:0] LATCH_HI = 16'(8 * BIT_CYCLES + 4);
    logic [15:0] low_run;
    logic [15:0] next_low_run;
    // saturates so a long idle line never wraps back into a window
    assign next_low_run = serial_data ? 16'h0000 : low_run + {15'h0000, ~&low_run};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_run <= 16'h0000;
        end else begin
            low_run <= next_low_run;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_lock_gap;
        $rose(packet_locked) |-> low_run inside {[LOCK_LO:LOCK_HI]};
    endproperty
    a_lock_gap: assert property (p_lock_gap) else $error("lock off end gap");
    property p_forward;
        packet_locked && $past(packet_locked) |-> serial_out == $past(serial_data);
    endproperty
    a_forward: assert property (p_forward) else $error("serial out not forwarding");
    property p_unlock_latch;
        $fell(packet_locked) |-> low_run inside {[LATCH_LO:LATCH_HI]};
    endproperty
    a_unlock_latch: assert property (p_unlock_latch) else $error("unlock off latch gap");
    property p_level_latch;
        $changed(level_ch0) |-> low_run inside {[LATCH_LO:LATCH_HI]};
    endproperty
    a_level_latch: assert property (p_level_latch) else $error("level moved off latch");
    property p_zero_off;
        (level_ch0 == 8'h00) [*4] |-> !sink_output[0];
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("sink on at zero level");
    property p_take;
        send_valid && send_ready |-> ##[1:2] !send_ready;
    endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_start;
        $fell(send_ready) |-> ##[0:1] serial_data;
    endproperty
    a_start: assert property (p_start) else $error("packet start missing");
    property p_gap_end;
        $rose(send_ready) |-> low_run >= 16'(5 * BIT_CYCLES);
    endproperty
    a_gap_end: assert property (p_gap_end) else $error("ready back before gap");
endmodule // clp_link_properties

/* File: testbench.sv */
// bench: host driving two chained devices, plus a direct line driver for traffic the host never sends
`timescale 1ns/1ps
module testbench;
    localparam int B = 48;
    typedef struct packed {
        logic [23:0] first;
        logic [23:0] second;
        logic [23:0] exp0;
        logic [23:0] exp1;
    } clp_row_t;
    logic        clk, reset_n, ce, send_valid, send_last, send_ready;
    logic        tb_line, tb_drive, out0, locked0, locked1;
    logic [23:0] send_levels;
    logic [7:0]  a0, a1, a2, b0, b1, b2;
    logic [2:0]  sink0, sink1;
    logic [31:0] got;
    int          mismatches, check_count, on;
    clp_row_t    rows [3];
    clp_link_if lnk();
    clp_link_if lnk_b();
    // second device hears the first one unless the bench takes its line over
    assign lnk_b.serial_data = tb_drive ? tb_line : out0;
    clp_host #(.BIT_CYCLES(B)) clp_host_i (.clk, .reset_n, .ce, .send_valid, .send_levels,
        .send_last, .send_ready, .link(lnk.host_end));
    clp_device clp_device_i0 (.clk, .reset_n, .ce, .link(lnk.device_end), .serial_out(out0),
        .level_ch0(a0), .level_ch1(a1), .level_ch2(a2), .sink_output(sink0),
        .packet_locked(locked0));
    clp_device clp_device_i1 (.clk, .reset_n, .ce, .link(lnk_b.device_end), .serial_out(),
        .level_ch0(b0), .level_ch1(b1), .level_ch2(b2), .sink_output(sink1),
        .packet_locked(locked1));
    clp_link_properties #(.BIT_CYCLES(B)) clp_link_properties_i (.clk, .reset_n,
        .serial_data(lnk.serial_data), .send_valid, .send_ready, .serial_out(out0),
        .packet_locked(locked0), .level_ch0(a0), .sink_output(sink0));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check_val(input logic [47:0] got_v, input logic [47:0] exp_v);
        check_count++;
        if (got_v !== exp_v) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask
    task automatic send(input logic [23:0] lv, input logic last);
        int n;
        n = 0;
        send_levels = lv;
        send_last = last;
        send_valid = 1'b1;
        @(negedge clk);
        send_valid = 1'b0;
        // sample mid way through the slot of the second pulse of each bit
        repeat (B / 4 + 3) @(negedge clk);
        for (int k = 31; k >= 0; k--) begin
            got[k] = lnk.serial_data;
            repeat (B) @(negedge clk);
        end
        check_val(48'(got), {16'h0000, 8'h3a, lv});
        while (send_ready !== 1'b1 && n < 12 * B) begin
            @(negedge clk);
            n++;
        end
        // a host that never returns to idle counts as a mismatch here
        check_val(48'(send_ready), 48'h1);
    endtask
    task automatic raw(input logic [31:0] pk, input int p, input int gap);
        for (int k = 31; k >= 0; k--) begin
            for (int c = 0; c < p; c++) begin
                tb_line = (c < p / 8) || (pk[k] && c >= p / 4 && c < p / 4 + p / 8);
                @(negedge clk);
            end
        end
        tb_line = 1'b0;
        repeat (gap) @(negedge clk);
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        ce = 1'b1;
        reset_n = 1'b0;
        send_valid = 1'b0;
        send_last = 1'b0;
        send_levels = 24'h000000;
        tb_line = 1'b0;
        tb_drive = 1'b0;
        mismatches = 0;
        check_count = 0;
        rows[0] = '{24'h123456, 24'hfedcba, 24'h123456, 24'hfedcba};
        rows[1] = '{24'hff0180, 24'h00ff01, 24'hff0180, 24'h00ff01};
        rows[2] = '{24'h000000, 24'h5aa5c3, 24'h000000, 24'h5aa5c3};
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        check_val({a0, a1, a2, b0, b1, b2}, 48'h0);
        check_val({42'h0, sink0, locked0, out0, send_ready}, 48'h1);
        $display("reset test done");
        foreach (rows[i]) begin
            send(rows[i].first, 1'b0);
            check_val({46'h0, locked0, locked1}, 48'h2);
            send(rows[i].second, 1'b1);
            repeat (4) @(negedge clk);
            check_val({a0, a1, a2, b0, b1, b2}, {rows[i].exp0, rows[i].exp1});
            check_val({46'h0, locked0, locked1}, 48'h0);
            on = 0;
            repeat (256) begin
                @(negedge clk);
                on += (sink0[0] === 1'b1) ? 1 : 0;
            end
            check_val(48'(on), 48'(rows[i].exp0[23:16]));
            $display("row %0d done", i);
        end
        // shortest legal period, then a slower one the host never uses
        tb_drive = 1'b1;
        raw({8'h3a, 24'h0c0d0e}, 42, 9 * 42);
        check_val(48'({b0, b1, b2}), 48'h0c0d0e);
        raw({8'h3a, 24'h800001}, 100, 900);
        check_val(48'({b0, b1, b2}), 48'h800001);
        raw({8'h3b, 24'h111111}, 100, 900);
        check_val(48'({b0, b1, b2}), 48'h800001);
        // frozen device must ignore a whole packet and its latch gap
        ce = 1'b0;
        raw({8'h3a, 24'h111111}, 42, 9 * 42);
        ce = 1'b1;
        @(negedge clk);
        check_val(48'({b0, b1, b2}), 48'h800001);
        check_val(48'(locked1), 48'h0);
        $display("direct line tests done");
        reset_n = 1'b0;
        @(negedge clk);
        check_val(48'({b0, b1, b2}), 48'h0);
        reset_n = 1'b1;
        repeat (300) @(negedge clk);
        check_val(48'(sink1), 48'h0);
        $display("second reset test done");
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule // testbench
